/* hdl/byte_fifo.sv */
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and one clock with clock enable.
*/
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             full;
  logic             empty;

  assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  assign empty    = (wrPtr == rdPtr);
  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = mem[rdPtr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (clkEn && inValid && !full)
      mem[wrPtr[AW-1:0]] <= inData;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wrPtr <= '0;
    else if (clkEn && inValid && !full)
      wrPtr <= wrPtr + (AW+1)'(1);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdPtr <= '0;
    else if (clkEn && outReady && !empty)
      rdPtr <= rdPtr + (AW+1)'(1);
  end
endmodule // byte_fifo

/* hdl/radio_host_interface.sv */
/*
  Host interface of the radio: SPI register slave, byte framer with transmit
  FIFO, bypass bit path clocked on the interrupt pin, shared interrupt pin,
  wake logic and signal-strength sampling.
  Assumes all pins are asynchronous to sys_clk and the modem side is synchronous.
*/
// What this block does
// - command bit 7 low means register read, high means register write
// - command bit 6 high advances address after each data byte, else repeats it
// - command byte carries six address bits, followed by eight-bit data bytes
// - bursts take any number of bytes and end only when select rises
// - transmit bytes are buffered so the next can be written during sending
// - each received byte overwrites the framer receive register unconditionally
// - bypass receive outputs update after each falling edge of interrupt pin while receive is on
// - bypass transmit lines are sampled on each falling interrupt-pin edge while transmit is on
// - transmit, receive and wake sources, each enableable, share one pin
// - transmit mode masks receive interrupts without altering stored enables
// - status registers show event conditions even when the source is disabled
// - configuration sets pin polarity: low is open drain, high open source
// - after power-down release host waits for wake before SPI transfers
// - wake enable bit 0 enables wake interrupt; status bit 0 shows pending
// - reading the wake status register clears the pending wake interrupt
// - four transmit events, enabled and reported through their own registers
// - eight receive events, four per channel, with enable and status registers
// - in 64-chip and paired-bit modes channel B receive events never fire
// - conversion starts after carrier holds over 50 us; result and valid bit
// - after a conversion the machine halts until receive is toggled
// - carrier sense bit 7 forces a conversion; host waits 50 us to read
// - power down low suspends and holds the buffered clock output at zero
// - interrupt pin serves as bypass bit clock when bypass mode is selected
// - multi-byte registers are little endian, lowest address least significant
`timescale 1ns/1ns
`include "radio_host_params.svh"
module radio_host_interface (
  input  wire logic                         sys_clk,
  input  wire logic                         nrst,
  input  wire logic                         clkEn,
  input  wire logic                         spiClk,
  input  wire logic                         spiDataIn,
  input  wire logic                         spiSelectN,
  output logic                              spiDataOut,
  output logic                              spiDataOeN,
  input  wire logic                         powerDownN,
  output logic                              bufferedSystemClockOut,
  output logic                              irqOut,
  output logic                              irqOeN,
  input  wire logic                         bypassDataIn,
  output logic                              bypassDataOut,
  output logic                              bypassDataOeN,
  input  wire logic                         bypassDataValidIn,
  output logic                              bypassDataValidOut,
  output logic                              bypassDataValidOeN,
  output logic                              rxEnabled,
  output logic                              txEnabled,
  output logic [7:0]                        txByte,
  output logic                              txByteValid,
  input  wire logic                         txByteReady,
  output logic                              txSpaceAvailable,
  input  wire logic [7:0]                   rxByte,
  input  wire logic                         rxByteValid,
  input  wire logic [3:0]                   txEventCond,
  input  wire logic [7:0]                   rxEventCond,
  input  wire radio_host_pkg::bypass_bits_t rxBits,
  output radio_host_pkg::bypass_bits_t      txBits,
  output logic                              txBitStrobe,
  input  wire logic                         carrierAbove,
  input  wire logic [4:0]                   adcLevel
);
  import radio_host_pkg::*;

  // pin synchronisers: first stage feeds only the second
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  logic       sckPrev;
  logic       sckSync;
  logic       mosiSync;
  logic       selSyncN;
  logic       pdSyncN;
  logic       bypDataSync;
  logic       bypValidSync;

  // register file
  logic [7:0] control;
  logic [7:0] dataRate;
  logic [7:0] settings;
  logic [7:0] framerCtl;
  logic [7:0] rxEn;
  logic [7:0] txEn;
  logic [7:0] wakeEn;
  logic [7:0] carrierSense;
  logic [7:0] rxDataA;
  logic [7:0] txDataLast;
  logic       wakePending;

  // spi engine
  spi_phase_t phase;
  spi_cmd_t   cmd;
  logic [2:0] bitCount;
  logic [7:0] shiftIn;
  logic [7:0] shiftOut;
  logic       shiftPending;
  logic       selected;
  logic       sckRise;
  logic       sckFall;
  logic       byteDone;
  logic [7:0] byteIn;
  logic [5:0] nextAddr;
  logic [5:0] loadAddr;
  logic       loadRead;
  logic       writeStrobe;
  logic       wakeClear;

  // interrupt, power and bypass
  logic [7:0] rxStatus;
  logic       irqEvent;
  logic       irqActive;
  logic       bypassOn;
  logic [9:0] oscCount;
  logic       oscStarted;
  logic       wakeSet;
  logic [3:0] bitDiv;
  logic       bitClk;
  logic       bitFall;
  logic [5:0] sigResult;

  // spi address arithmetic shared by read loading and write targeting
  function automatic logic [5:0] advance(input spi_cmd_t c);
    advance = c.incr ? c.addr + `ADDR_STEP : c.addr;
  endfunction

  function automatic logic [7:0] regRead(input logic [5:0] a);
    case (a)
      `ADDR_CONTROL:       regRead = control;
      `ADDR_DATA_RATE:     regRead = dataRate;
      `ADDR_CONFIG:        regRead = settings;
      `ADDR_FRAMER_CTL:    regRead = framerCtl;
      `ADDR_RX_EN:         regRead = rxEn;
      `ADDR_RX_STAT:       regRead = rxStatus;
      `ADDR_RX_DATA_A:     regRead = rxDataA;
      `ADDR_TX_EN:         regRead = txEn;
      `ADDR_TX_STAT:       regRead = {4'h0, txEventCond};
      `ADDR_TX_DATA:       regRead = txDataLast;
      `ADDR_WAKE_EN:       regRead = wakeEn;
      `ADDR_WAKE_STAT:     regRead = {7'h00, wakePending};
      `ADDR_SIG_STRENGTH:  regRead = {2'h0, sigResult};
      `ADDR_CARRIER_SENSE: regRead = carrierSense;
      default:             regRead = `RST_ZERO;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinMeta <= 6'h1f;
      pinSync <= 6'h1f;
    end
    else if (clkEn)
    begin
      pinMeta <= {spiClk, spiDataIn, spiSelectN, powerDownN, bypassDataIn, bypassDataValidIn};
      pinSync <= pinMeta;
    end
  end

  assign {sckSync, mosiSync, selSyncN, pdSyncN, bypDataSync, bypValidSync} = pinSync;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      sckPrev <= 1'b0;
    else if (clkEn)
      sckPrev <= sckSync;
  end

  assign selected    = ~selSyncN;
  assign sckRise     = selected & sckSync & ~sckPrev;
  assign sckFall     = selected & ~sckSync & sckPrev;
  assign byteDone    = sckRise && bitCount == `BIT_LAST;
  assign byteIn      = {shiftIn[6:0], mosiSync};
  assign nextAddr    = advance(cmd);
  assign loadAddr    = (phase == PH_CMD) ? byteIn[5:0] : nextAddr;
  assign loadRead    = byteDone && ((phase == PH_CMD) ? ~byteIn[7] : ~cmd.write);
  assign writeStrobe = byteDone && phase == PH_DATA && cmd.write;
  assign wakeClear   = loadRead && loadAddr == `ADDR_WAKE_STAT;

  // deselect is the only way out of a burst
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase    <= PH_CMD;
      cmd      <= '0;
      bitCount <= 3'h0;
      shiftIn  <= 8'h00;
    end
    else if (clkEn)
    begin
      if (!selected)
      begin
        phase    <= PH_CMD;
        bitCount <= 3'h0;
      end
      else if (sckRise)
      begin
        shiftIn  <= byteIn;
        bitCount <= bitCount + 3'h1;
        if (byteDone && phase == PH_CMD)
        begin
          cmd   <= byteIn;
          phase <= PH_DATA;
        end
        else if (byteDone)
          cmd.addr <= nextAddr;
      end
    end
  end

  // msb leaves on the falling edge; a freshly loaded byte is not shifted
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shiftOut     <= 8'h00;
      shiftPending <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!selected)
      begin
        shiftOut     <= 8'h00;
        shiftPending <= 1'b0;
      end
      else if (byteDone)
      begin
        shiftOut     <= loadRead ? regRead(loadAddr) : 8'h00;
        shiftPending <= 1'b0;
      end
      else if (sckRise)
        shiftPending <= 1'b1;
      else if (sckFall && shiftPending)
      begin
        shiftOut     <= {shiftOut[6:0], 1'b0};
        shiftPending <= 1'b0;
      end
    end
  end

  assign spiDataOut = shiftOut[7];
  assign spiDataOeN = ~selected;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      control      <= `RST_ZERO;
      dataRate     <= `RST_ZERO;
      settings     <= `RST_CONFIG;
      framerCtl    <= `RST_FRAMER;
      rxEn         <= `RST_ZERO;
      txEn         <= `RST_ZERO;
      wakeEn       <= `RST_ZERO;
      carrierSense <= `RST_ZERO;
      txDataLast   <= `RST_ZERO;
    end
    else if (clkEn && writeStrobe)
    begin
      case (cmd.addr)
        `ADDR_CONTROL:       control      <= byteIn;
        `ADDR_DATA_RATE:     dataRate     <= byteIn;
        `ADDR_CONFIG:        settings     <= byteIn;
        `ADDR_FRAMER_CTL:    framerCtl    <= byteIn;
        `ADDR_RX_EN:         rxEn         <= byteIn;
        `ADDR_TX_EN:         txEn         <= byteIn;
        `ADDR_WAKE_EN:       wakeEn       <= byteIn;
        `ADDR_CARRIER_SENSE: carrierSense <= byteIn;
        `ADDR_TX_DATA:       txDataLast   <= byteIn;
        default:             txDataLast   <= txDataLast;
      endcase
    end
  end

  // a full fifo drops the byte; software watches the space flag first
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (8)
  ) txFifo (
    .clk      (sys_clk),
    .nrst     (nrst),
    .clkEn    (clkEn),
    .inData   (byteIn),
    .inValid  (writeStrobe && cmd.addr == `ADDR_TX_DATA),
    .inReady  (txSpaceAvailable),
    .outData  (txByte),
    .outValid (txByteValid),
    .outReady (txByteReady)
  );

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rxDataA <= `RST_ZERO;
    else if (clkEn && rxByteValid)
      rxDataA <= rxByte;
  end

  assign rxEnabled = control[`CTL_RX_BIT];
  assign txEnabled = control[`CTL_TX_BIT];
  assign bypassOn  = framerCtl[`FRAMER_BYPASS_BIT];

  always_comb
  begin
    rxStatus = rxEventCond & `CHAN_BOTH;
    if (dataRate[`RATE_MODE_MSB:0] == `RATE_64_CHIPS || dataRate[`RATE_MODE_MSB:0] == `RATE_PAIRED)
      rxStatus = rxEventCond & `CHAN_A_ONLY;
  end

  // modes mask the opposite direction; the enable registers stay untouched
  assign irqEvent = (|(txEventCond & txEn[3:0]) & ~rxEnabled)
                  | (|(rxStatus & rxEn) & ~txEnabled)
                  | (wakePending & wakeEn[`WAKE_EN_BIT]);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      irqActive <= 1'b0;
    else if (clkEn)
      irqActive <= irqEvent;
  end

  always_comb
  begin
    if (bypassOn)
    begin
      irqOut = bitClk;
      irqOeN = 1'b0;
    end
    else
    begin
      irqOut = settings[`CFG_IRQ_HIGH_BIT];
      irqOeN = ~irqActive;
    end
  end

  // oscillator start-up after power-down release raises the wake event
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oscCount   <= 10'h000;
      oscStarted <= 1'b0;
    end
    else if (clkEn)
    begin
      if (!pdSyncN)
      begin
        oscCount   <= 10'h000;
        oscStarted <= 1'b0;
      end
      else if (!oscStarted)
      begin
        oscCount   <= oscCount + 10'h001;
        oscStarted <= (oscCount == 10'(`OSC_START_CYCLES));
      end
    end
  end

  assign wakeSet = pdSyncN && !oscStarted && oscCount == 10'(`OSC_START_CYCLES);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      wakePending <= `RST_WAKE_PENDING;
    else if (clkEn && wakeSet)
      wakePending <= 1'b1;
    else if (clkEn && wakeClear)
      wakePending <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      bufferedSystemClockOut <= 1'b0;
    else if (clkEn)
      bufferedSystemClockOut <= oscStarted ? ~bufferedSystemClockOut : 1'b0;
  end

  // bypass bit clock runs only in bypass mode
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitDiv  <= 4'h0;
      bitClk  <= 1'b1;
      bitFall <= 1'b0;
    end
    else if (clkEn)
    begin
      bitFall <= 1'b0;
      if (!bypassOn)
      begin
        bitDiv <= 4'h0;
        bitClk <= 1'b1;
      end
      else if (bitDiv == 4'(`BYP_HALF_CYCLES - 1))
      begin
        bitDiv  <= 4'h0;
        bitClk  <= ~bitClk;
        bitFall <= bitClk;
      end
      else
        bitDiv <= bitDiv + 4'h1;
    end
  end

  // receive bits change one clock after the falling edge so the host has three clocks before the rise
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bypassDataOut      <= 1'b0;
      bypassDataValidOut <= 1'b0;
    end
    else if (clkEn && bitFall && rxEnabled)
    begin
      bypassDataOut      <= rxBits.data;
      bypassDataValidOut <= rxBits.valid;
    end
  end

  assign bypassDataOeN      = ~(bypassOn & rxEnabled);
  assign bypassDataValidOeN = ~(bypassOn & rxEnabled);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txBits      <= '0;
      txBitStrobe <= 1'b0;
    end
    else if (clkEn)
    begin
      txBitStrobe <= bitFall && txEnabled;
      if (bitFall && txEnabled)
        txBits <= '{data: bypDataSync, valid: bypValidSync};
    end
  end

  signal_strength_fsm sigFsm (
    .clk          (sys_clk),
    .nrst         (nrst),
    .clkEn        (clkEn),
    .rxOn         (rxEnabled),
    .carrierAbove (carrierAbove),
    .forceConv    (carrierSense[`CARRIER_FORCE_BIT]),
    .adcLevel     (adcLevel),
    .result       (sigResult),
    .state        ()
  );
endmodule // radio_host_interface

/* hdl/radio_host_params.svh */
/*
  Named constants of the radio host interface: register offsets, reset values,
  field positions and timing counts.
  Assumes it is included by bare name by the design modules.
*/
`ifndef RADIO_HOST_PARAMS_SVH
`define RADIO_HOST_PARAMS_SVH

// register offsets (six-bit address space)
`define ADDR_CONTROL        6'h03
`define ADDR_DATA_RATE      6'h04
`define ADDR_CONFIG         6'h05
`define ADDR_FRAMER_CTL     6'h06
`define ADDR_RX_EN          6'h07
`define ADDR_RX_STAT        6'h08
`define ADDR_RX_DATA_A      6'h09
`define ADDR_TX_EN          6'h0d
`define ADDR_TX_STAT        6'h0e
`define ADDR_TX_DATA        6'h0f
`define ADDR_WAKE_EN        6'h1c
`define ADDR_WAKE_STAT      6'h1d
`define ADDR_SIG_STRENGTH   6'h22
`define ADDR_CARRIER_SENSE  6'h2f
`define ADDR_STEP           6'h01

// reset values
`define RST_ZERO            8'h00
`define RST_CONFIG          8'h01
`define RST_FRAMER          8'h03
`define RST_WAKE_PENDING    1'b1

// field positions
`define CTL_RX_BIT          7
`define CTL_TX_BIT          6
`define CFG_IRQ_HIGH_BIT    0
`define FRAMER_BYPASS_BIT   7
`define FRAMER_SPACE_BIT    6
`define WAKE_EN_BIT         0
`define CARRIER_FORCE_BIT   7
`define RATE_MODE_MSB       1
`define RATE_64_CHIPS       2'h0
`define RATE_PAIRED         2'h3
`define CHAN_A_ONLY         8'h0f
`define CHAN_BOTH           8'hff
`define BIT_LAST            3'h7

// timing
`define SYS_CLK_PERIOD_NS   100
`define SIG_QUAL_TIME_NS    50000
`define SIG_QUAL_CYCLES     ((`SIG_QUAL_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define OSC_START_TIME_NS   2000
`define OSC_START_CYCLES    ((`OSC_START_TIME_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define BYP_HALF_TIME_NS    400
`define BYP_HALF_CYCLES     (`BYP_HALF_TIME_NS / `SYS_CLK_PERIOD_NS)

`endif

/* hdl/radio_host_pkg.sv */
/*
  Types shared by the radio host interface modules.
  Assumes nothing of its surroundings.
*/
package radio_host_pkg;

  typedef struct packed {
    logic       write;
    logic       incr;
    logic [5:0] addr;
  } spi_cmd_t;

  typedef struct packed {
    logic data;
    logic valid;
  } bypass_bits_t;

  typedef enum logic [1:0] {
    SIG_IDLE    = 2'h0,
    SIG_QUALIFY = 2'h1,
    SIG_CONVERT = 2'h3,
    SIG_HALT    = 2'h2
  } sig_state_t;

  typedef enum logic {
    PH_CMD  = 1'b0,
    PH_DATA = 1'b1
  } spi_phase_t;

endpackage

/* hdl/signal_strength_fsm.sv */
/*
  Signal-strength sampling state machine: qualifies a carrier, converts once,
  then halts until receive is switched off.
  Assumes carrier and converter inputs are synchronous to clk.
*/
`timescale 1ns/1ns
`include "radio_host_params.svh"
module signal_strength_fsm (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      clkEn,
  input  wire logic                      rxOn,
  input  wire logic                      carrierAbove,
  input  wire logic                      forceConv,
  input  wire logic [4:0]                adcLevel,
  output logic [5:0]                     result,
  output radio_host_pkg::sig_state_t     state
);
  import radio_host_pkg::*;

  sig_state_t next_state;
  logic [9:0] qualCount;

  always_comb
  begin
    next_state = state;
    case (state)
      SIG_IDLE:    next_state = forceConv ? SIG_CONVERT : (carrierAbove ? SIG_QUALIFY : SIG_IDLE);
      SIG_QUALIFY:
      begin
        if (forceConv)
          next_state = SIG_CONVERT;
        else if (!carrierAbove)
          next_state = SIG_IDLE;
        else if (qualCount == 10'(`SIG_QUAL_CYCLES))
          next_state = SIG_CONVERT;
      end
      SIG_CONVERT: next_state = SIG_HALT;
      SIG_HALT:    next_state = SIG_HALT;
      default:     next_state = SIG_IDLE;
    endcase
    if (!rxOn)
      next_state = SIG_IDLE;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state <= SIG_IDLE;
    else if (clkEn)
      state <= next_state;
  end

  // counts past the qualifying time so the carrier must stay over it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      qualCount <= '0;
    else if (clkEn)
      qualCount <= (state == SIG_QUALIFY) ? qualCount + 10'h001 : 10'h000;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      result <= 6'h00;
    else if (clkEn && state == SIG_CONVERT)
      result <= {1'b1, adcLevel};
    else if (clkEn && state == SIG_IDLE && next_state != SIG_IDLE)
      result <= 6'h00;
  end
endmodule // signal_strength_fsm

/* tb/radio_host_interface_tb.sv */
/* self-checking bench of the radio host interface
   assumes the host model drives the spi pins */
`timescale 1ns/1ns
module radio_host_interface_tb;
  import radio_host_pkg::*;
  logic sys_clk, nrst, powerDownN, txByteReady, rxByteValid, carrierAbove, txByteValid;
  logic spiClk, spiDataIn, spiSelectN, spiDataOut, bypassDataIn, bypassDataValidIn;
  logic irqOut, bypassDataOut, bypassDataOeN, txSpaceAvailable, txBitStrobe;
  logic [7:0] rxByte, rxEventCond, txByte, v, b;
  logic [3:0] txEventCond;
  logic [4:0] adcLevel;
  logic [5:0] rwAddr [5] = '{6'h05, 6'h07, 6'h0d, 6'h1c, 6'h2f};
  bypass_bits_t rxBits, txBits;
  int err_count, tests_run;
  spi_host_model i_host (.spiClk, .spiDataIn, .spiSelectN, .spiDataOut);
  radio_host_interface i_dut (.sys_clk, .nrst, .clkEn(1'b1), .spiClk, .spiDataIn, .spiSelectN,
    .spiDataOut, .spiDataOeN(), .powerDownN, .bufferedSystemClockOut(), .irqOut, .irqOeN(),
    .bypassDataIn, .bypassDataOut, .bypassDataOeN, .bypassDataValidIn, .bypassDataValidOut(),
    .bypassDataValidOeN(), .rxEnabled(), .txEnabled(), .txByte, .txByteValid, .txByteReady,
    .txSpaceAvailable, .rxByte, .rxByteValid, .txEventCond, .rxEventCond, .rxBits, .txBits,
    .txBitStrobe, .carrierAbove, .adcLevel);
  function automatic logic [7:0] rxMask(input logic [1:0] r, input logic [7:0] c);
    return (r == 2'h0 || r == 2'h3) ? (c & 8'h0f) : c;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr1(input logic [5:0] a, input logic [7:0] d);
    i_host.wr[0] = d;
    i_host.xfer({2'b10, a}, 1);
  endtask
  task automatic rd1(input logic [5:0] a, output logic [7:0] d);
    i_host.xfer({2'b00, a}, 1);
    d = i_host.rd[0];
  endtask
  task automatic waitIrq(input logic lvl);
    for (int n = 0; n < 100 && irqOut !== lvl; n++)
      @(negedge sys_clk);
    if (irqOut !== lvl)
    begin
      err_count++;
      summarize();
    end
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    {nrst, txByteReady, rxByteValid, carrierAbove, rxByte, rxBits} = '0;
    powerDownN = 1'b1;
    v = 8'($urandom(66236));
    {txEventCond, rxEventCond, adcLevel, bypassDataIn, bypassDataValidIn} = 19'($urandom);
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
    // oscillator start takes 20 cycles, the host waits past it
    repeat (40) @(posedge sys_clk);
    rd1(6'h1d, v);
    check("wake pending", v, 8'h01);
    rd1(6'h1d, v);
    check("wake cleared", v, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      b = 8'($urandom);
      wr1(rwAddr[i], b);
      rd1(rwAddr[i], v);
      check("register", v, b);
    end
    wr1(6'h2f, 8'h00);
    wr1(6'h0e, 8'hff);
    rd1(6'h0e, v);
    check("tx status", v, {4'h0, txEventCond});
    rd1(6'h3a, v);
    check("unmapped", v, 8'h00);
    for (int r = 0; r < 4; r++)
    begin
      wr1(6'h04, 8'(r));
      rd1(6'h08, v);
      check("rx status", v, rxMask(2'(r), rxEventCond));
    end
    wr1(6'h1c, 8'h01);
    i_host.xfer(8'h5c, 2);
    check("burst incr", i_host.rd[1], 8'h00);
    i_host.xfer(8'h1c, 2);
    check("burst same", i_host.rd[1], 8'h01);
    $display("register tests done");
    for (int k = 0; k < 9; k++)
      i_host.wr[k] = 8'($urandom);
    i_host.xfer(8'h8f, 9);
    check("fifo full", {7'h0, txSpaceAvailable}, 8'h00);
    @(posedge sys_clk) #1 txByteReady = 1'b1;
    for (int k = 0; k < 8; k++)
      @(negedge sys_clk) check("fifo byte", txByte, i_host.wr[k]);
    @(posedge sys_clk) #1 txByteReady = 1'b0;
    check("fifo empty", {7'h0, txByteValid}, 8'h00);
    {rxByte, rxByteValid} = {8'($urandom), 1'b1};
    @(posedge sys_clk);
    #1 b = 8'($urandom);
    rxByte = b;
    @(posedge sys_clk);
    #1 rxByteValid = 1'b0;
    rd1(6'h09, v);
    check("rx overwrite", v, b);
    $display("framer tests done");
    wr1(6'h03, 8'h00);
    wr1(6'h03, 8'h80);
    carrierAbove = 1'b1;
    b = {3'b001, adcLevel};
    repeat (520) @(posedge sys_clk);
    #1 adcLevel = ~adcLevel;
    rd1(6'h22, v);
    check("strength", v, b);
    repeat (600) @(posedge sys_clk);
    rd1(6'h22, v);
    check("strength halt", v, b);
    rxBits = 2'($urandom);
    wr1(6'h06, 8'h83);
    waitIrq(1'b0);
    repeat (2) @(posedge sys_clk);
    check("bypass rx", {7'h0, bypassDataOut}, {7'h0, rxBits.data});
    // tx pins held long before every falling edge
    wr1(6'h03, 8'h40);
    waitIrq(1'b1);
    waitIrq(1'b0);
    waitIrq(1'b1);
    check("bypass tx", {6'h0, txBits}, {6'h0, bypassDataIn, bypassDataValidIn});
    $display("bypass and strength tests done");
    #1 powerDownN = 1'b0;
    repeat (6) @(posedge sys_clk);
    summarize();
  end
endmodule // radio_host_interface_tb

/* tb/radio_host_props.sv */
/* pin checker of the radio host interface
   assumes a bind into radio_host_interface, one clock domain */
`timescale 1ns/1ns
module radio_host_props (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       spiSelectN,
  input wire logic       spiDataOeN,
  input wire logic       powerDownN,
  input wire logic       bufferedSystemClockOut,
  input wire logic       irqOut,
  input wire logic       bypassDataOut,
  input wire logic       bypassDataOeN,
  input wire logic [7:0] txByte,
  input wire logic       txByteValid,
  input wire logic       txByteReady,
  input wire logic       txSpaceAvailable,
  input wire logic       txBitStrobe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [4:0] upCnt;
  // saturates once the oscillator start time has surely passed
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      upCnt <= 5'h00;
    else if (!powerDownN)
      upCnt <= 5'h00;
    else if (upCnt != 5'h1f)
      upCnt <= upCnt + 5'h01;
  end
  sequence deselected;
    spiSelectN [*3];
  endsequence
  sequence bitFall;
    !bypassDataOeN && !irqOut && $past(irqOut);
  endsequence
  miso_release_a: assert property (deselected |-> spiDataOeN) else $error("miso driven");
  clk_held_a: assert property (!powerDownN [*5] |-> !bufferedSystemClockOut)
    else $error("clock out runs in power down");
  clk_runs_a: assert property (upCnt == 5'h1f |=> $changed(bufferedSystemClockOut))
    else $error("clock out stuck");
  fifo_hold_a: assert property (txByteValid && !txByteReady |=> txByteValid && $stable(txByte))
    else $error("fifo head lost");
  fifo_full_a: assert property (!txSpaceAvailable |-> txByteValid) else $error("full but empty");
  strobe_once_a: assert property (txBitStrobe |=> !txBitStrobe) else $error("strobe too long");
  rx_update_a: assert property (!bypassDataOeN && $changed(bypassDataOut) |->
    !$past(irqOut) && $past(irqOut, 2)) else $error("bypass out moved off the fall");
  bit_clock_a: assert property (bitFall |=> !irqOut [*3] ##1 irqOut)
    else $error("bit clock low phase wrong");
endmodule // radio_host_props
bind radio_host_interface radio_host_props i_props (.sys_clk, .nrst, .spiSelectN, .spiDataOeN,
  .powerDownN, .bufferedSystemClockOut, .irqOut, .bypassDataOut, .bypassDataOeN, .txByte,
  .txByteValid, .txByteReady, .txSpaceAvailable, .txBitStrobe);

/* tb/spi_host_model.sv */
/* spi master model of the host controller
   assumes mode 0 timing with an 800 ns bit period */
`timescale 1ns/1ns
module spi_host_model (
  output logic      spiClk,
  output logic      spiDataIn,
  output logic      spiSelectN,
  input  wire logic spiDataOut
);
  logic [7:0] wr [16];
  logic [7:0] rd [16];
  initial
  begin
    spiClk = 1'b0;
    spiDataIn = 1'b0;
    spiSelectN = 1'b1;
  end
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spiDataIn = tx[i];
      #400 spiClk = 1'b1;
      rx[i] = spiDataOut;
      #400 spiClk = 1'b0;
    end
  endtask
  task automatic xfer(input logic [7:0] cmd, input int n);
    logic [7:0] junk;
    #1 spiSelectN = 1'b0;
    shift(cmd, junk);
    for (int k = 0; k < n; k++)
      shift(wr[k], rd[k]);
    #400 spiSelectN = 1'b1;
    spiDataIn = ~spiDataIn;
    #400;
  endtask
endmodule // spi_host_model
